/* verilog/cpu_bus_cycle_sequencer.sv */
`timescale 1ns/100ps

module cpu_bus_cycle_sequencer (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  input  wire bus_seq_pkg::bus_req_s req,
  output logic                       req_ready,
  output logic                       resp_valid,
  output logic [63:0]                resp_data,
  input  wire logic                  vector_busy,
  output logic                       dsp_strobe,
  output logic                       dsp_write,
  output logic [23:0]                dsp_addr,
  output logic [15:0]                dsp_wdata,
  input  wire logic [15:0]           dsp_rdata,
  input  wire logic [15:0]           addr_data_low_in,
  output logic [15:0]                addr_data_low_out,
  output logic                       addr_data_low_oe,
  output logic [7:0]                 upper_address,
  output logic                       high_byte_enable_n,
  output logic                       addr_latch_enable,
  output logic                       address_strobe_n,
  output logic                       timing_state_out_n,
  output logic                       data_buffer_enable_n,
  output logic                       read_strobe_n,
  output logic                       write_strobe_n,
  output logic                       internal_access_strobe_n,
  output logic                       slave_cycle_strobe_n,
  output logic                       data_direction_in_n,
  output logic [3:0]                 cycle_status,
  input  wire logic                  continuous_wait_n
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_VWAIT, ST_T1, ST_T2, ST_T3, ST_T4,
    ST_SLEAD, ST_SL1, ST_SL4
  } seq_state_e;

  seq_state_e            state_r;
  seq_state_e            state_nxt;
  bus_seq_pkg::bus_req_s req_r;
  bus_seq_pkg::bus_req_s cur_req;
  logic [2:0]            step_r;
  logic [23:0]           cur_addr_r;
  logic [15:0]           wlane_r;
  logic [1:0]            cat_r;
  logic [2:0]            off_r;
  logic [63:0]           rdata_r;
  logic                  resp_r;
  logic                  continuous_wait_meta_r;
  logic                  continuous_wait_sync_r;
  logic [15:0]           ad_meta_r;
  logic [15:0]           ad_sync_r;
  bus_seq_pkg::piece_s   piece;
  logic [2:0]            count;
  logic [2:0]            pc_step;
  logic                  last_piece;
  logic                  special;
  logic                  slave;
  logic                  in_cycle;
  logic [15:0]           lane_nxt;
  logic [15:0]           rd_lane;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      continuous_wait_meta_r <= 1'b1;
      continuous_wait_sync_r <= 1'b1;
      ad_meta_r    <= 16'h0;
      ad_sync_r    <= 16'h0;
    end
    else
    begin
      continuous_wait_meta_r <= continuous_wait_n;
      continuous_wait_sync_r <= continuous_wait_meta_r;
      ad_meta_r    <= addr_data_low_in;
      ad_sync_r    <= ad_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // operand splitting
  // ---------------------------------------------------------------
  // while idle the request is not latched yet, so split it off the port
  assign cur_req = (state_r == ST_IDLE) ? req : req_r;
  assign pc_step = (state_r == ST_IDLE) ? 3'h0
                 : (state_r == ST_T4 || state_r == ST_SL4) ? step_r + 3'h1
                 : step_r;

  operand_splitter u_split (
    .size  (cur_req.size),
    .odd   (cur_req.addr[0]),
    .step  (pc_step),
    .piece (piece),
    .count (count)
  );

  assign special    = (req_r.kind == bus_seq_pkg::KIND_SPECIAL);
  assign slave      = (req_r.kind == bus_seq_pkg::KIND_SLAVE);
  assign last_piece = (step_r + 3'h1 >= count);

  always_comb
  begin
    // byte lanes for the piece about to start
    lane_nxt = 16'h0;
    unique case (piece.cat)
      bus_seq_pkg::CAT_ODD_BYTE:
        lane_nxt[15:8] = cur_req.wdata[8*piece.off +: 8];
      bus_seq_pkg::CAT_EVEN_BYTE:
        lane_nxt[7:0]  = cur_req.wdata[8*piece.off +: 8];
      default:
        lane_nxt = cur_req.wdata[8*piece.off +: 16];
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (req_valid)
        begin
          if (req.kind == bus_seq_pkg::KIND_SLAVE)
            state_nxt = ST_SLEAD;
          else if (req.kind == bus_seq_pkg::KIND_SPECIAL)
            state_nxt = ST_VWAIT;
          else
            state_nxt = ST_T1;
        end
      ST_VWAIT:
        if (!vector_busy)
          state_nxt = ST_T1;
      ST_T1:    state_nxt = ST_T2;
      ST_T2:    state_nxt = ST_T3;
      ST_T3:
        // special cycles never stretch
        if (special || continuous_wait_sync_r)
          state_nxt = ST_T4;
      ST_T4:    state_nxt = last_piece ? ST_IDLE : ST_T1;
      ST_SLEAD: state_nxt = ST_SL1;
      ST_SL1:   state_nxt = ST_SL4;
      ST_SL4:   state_nxt = last_piece ? ST_IDLE : ST_SL1;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_r  <= '0;
      step_r <= 3'h0;
    end
    else if (state_r == ST_IDLE && req_valid)
    begin
      req_r  <= req;
      step_r <= 3'h0;
    end
    else if (state_r == ST_T4 || state_r == ST_SL4)
      step_r <= step_r + 3'h1;
  end

  // ---------------------------------------------------------------
  // per-cycle address and write lanes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur_addr_r <= bus_seq_pkg::ADDR_RESET;
      wlane_r    <= 16'h0;
      cat_r      <= bus_seq_pkg::CAT_EVEN_WORD;
      off_r      <= 3'h0;
    end
    else if (state_nxt == ST_T1)
    begin
      // byte address arithmetic wraps at 24 bits
      cur_addr_r <= cur_req.addr + 24'(piece.off);
      wlane_r    <= lane_nxt;
      cat_r      <= piece.cat;
      off_r      <= piece.off;
    end
    else if (state_nxt == ST_SL1)
    begin
      // lead state counts as step zero for lane selection
      if (req_r.size == bus_seq_pkg::SIZE_BYTE)
        wlane_r <= {8'h0, req_r.wdata[7:0]};
      else
        wlane_r <= req_r.wdata[16*pc_step[1:0] +: 16];
    end
  end

  // ---------------------------------------------------------------
  // read assembly
  // ---------------------------------------------------------------
  // special reads ignore the pins and take the module's data
  assign rd_lane = special ? dsp_rdata : ad_sync_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_r <= bus_seq_pkg::OPND_RESET;
    else if (state_r == ST_IDLE && req_valid)
      rdata_r <= bus_seq_pkg::OPND_RESET;
    else if (state_r == ST_SL1 && !req_r.write)
    begin
      if (req_r.size == bus_seq_pkg::SIZE_BYTE)
        rdata_r[7:0] <= ad_sync_r[7:0];
      else
        rdata_r[16*step_r[1:0] +: 16] <= ad_sync_r;
    end
    else if (state_r == ST_T4 && !req_r.write) // synced pins show T2
    begin
      unique case (cat_r)
        bus_seq_pkg::CAT_ODD_BYTE:
          rdata_r[8*off_r +: 8] <= rd_lane[15:8];
        bus_seq_pkg::CAT_EVEN_BYTE:
          rdata_r[8*off_r +: 8] <= rd_lane[7:0];
        default:
          rdata_r[8*off_r +: 16] <= rd_lane;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      resp_r <= 1'b0;
    else
      resp_r <= (state_nxt == ST_IDLE) && (state_r == ST_T4
                || state_r == ST_SL4);
  end

  assign req_ready  = (state_r == ST_IDLE);
  assign resp_valid = resp_r;
  assign resp_data  = rdata_r;

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign in_cycle = (state_r == ST_T1) || (state_r == ST_T2)
                 || (state_r == ST_T3) || (state_r == ST_T4);

  always_comb
  begin
    addr_data_low_out = (state_r == ST_T1) ? cur_addr_r[15:0] : wlane_r;
    // address phase drives always, data phase only on writes
    addr_data_low_oe  = (in_cycle && (state_r == ST_T1 || req_r.write))
                     || ((state_r == ST_SL1 || state_r == ST_SL4)
                         && req_r.write);
    upper_address     = in_cycle ? cur_addr_r[23:16] : 8'h0;
    high_byte_enable_n = in_cycle ? cat_r[1] : 1'b1;
    addr_latch_enable = (in_cycle && special) || (state_r == ST_T1);
    address_strobe_n  = !(state_r == ST_T1 && !special);
    timing_state_out_n = !(!special && !slave
                        && (state_r == ST_T2 || state_r == ST_T3));
    data_buffer_enable_n = timing_state_out_n;
    read_strobe_n     = timing_state_out_n || req_r.write;
    write_strobe_n    = timing_state_out_n || !req_r.write;
    internal_access_strobe_n = !(state_r == ST_T1 && special);
    slave_cycle_strobe_n = !(state_r == ST_SL1);
    data_direction_in_n = !((in_cycle || state_r == ST_SL1
                         || state_r == ST_SL4) && !req_r.write);
    if (state_r == ST_SLEAD || state_r == ST_SL1 || state_r == ST_SL4)
      cycle_status = bus_seq_pkg::STATUS_SLAVE;
    else if (in_cycle)
      cycle_status = special ? bus_seq_pkg::STATUS_SIGNAL_PROCESSING_MODULE
                             : bus_seq_pkg::STATUS_DATA;
    else
      cycle_status = bus_seq_pkg::STATUS_IDLE;
  end

  assign dsp_strobe = (state_r == ST_T1) && special;
  assign dsp_write  = req_r.write;
  assign dsp_addr   = cur_addr_r;
  assign dsp_wdata  = wlane_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_special_quiet_pins: assert property (
    (in_cycle && special) |-> (addr_latch_enable && address_strobe_n
      && timing_state_out_n && read_strobe_n && write_strobe_n))
    else $error("special cycle activated a memory strobe");
  a_vector_hold_wait: assert property (
    (state_r == ST_VWAIT && vector_busy) |=> (state_r == ST_VWAIT
      && internal_access_strobe_n && cycle_status == 4'h0))
    else $error("module access not held during vector operation");
  a_special_write_echo: assert property (
    (state_r == ST_T2 && special && req_r.write)
      |-> (addr_data_low_oe && addr_data_low_out == dsp_wdata))
    else $error("special write data not on bus");
  a_special_addr_out: assert property (
    (state_r == ST_T1 && special)
      |-> ({upper_address, addr_data_low_out} == dsp_addr))
    else $error("special cycle address wrong");
  a_slave_two_clocks: assert property (
    $fell(slave_cycle_strobe_n) |=> $rose(slave_cycle_strobe_n)
      ##1 (state_r == ST_SL1 || state_r == ST_IDLE))
    else $error("slave cycle not two clocks");
  a_status_lead_slave: assert property (
    $fell(slave_cycle_strobe_n) |-> $past(cycle_status) == 4'hD)
    else $error("status did not lead slave strobe");
  a_slave_no_strobes: assert property (
    (state_r == ST_SL1 || state_r == ST_SL4) |-> (address_strobe_n
      && read_strobe_n && write_strobe_n && data_buffer_enable_n))
    else $error("memory strobe during slave cycle");
  a_category_legal: assert property (
    (state_r == ST_T1) |-> !(high_byte_enable_n && cur_addr_r[0]))
    else $error("illegal byte enable and bit zero pair");
  a_no_idle_gap: assert property (
    (state_r == ST_T4 && !last_piece) |=> (state_r == ST_T1))
    else $error("idle state between operand cycles");
  c_special_write: cover property (
    (state_r == ST_T1 && special && req_r.write) ##4 resp_valid);
  c_slave_quad: cover property (
    (state_r == ST_SL4 && req_r.size == bus_seq_pkg::SIZE_QUAD
      && step_r == 3'h3));
  c_odd_double: cover property (
    (state_r == ST_T1 && req_r.addr[0]
      && req_r.size == bus_seq_pkg::SIZE_DOUBLE && step_r == 3'h2));

endmodule : cpu_bus_cycle_sequencer

/* pkg/bus_seq_pkg.sv */
package bus_seq_pkg;

  // ---------------------------------------------------------------
  // cycle status codes
  // ---------------------------------------------------------------
  localparam logic [3:0] STATUS_IDLE  = 4'h0;
  localparam logic [3:0] STATUS_SIGNAL_PROCESSING_MODULE  = 4'h2;
  localparam logic [3:0] STATUS_DATA  = 4'hA;
  localparam logic [3:0] STATUS_SLAVE = 4'hD;

  // ---------------------------------------------------------------
  // bus cycle categories, coded as {high_byte_enable_n, bit zero}
  // ---------------------------------------------------------------
  localparam logic [1:0] CAT_EVEN_BYTE = 2'h2;
  localparam logic [1:0] CAT_ODD_BYTE  = 2'h1;
  localparam logic [1:0] CAT_EVEN_WORD = 2'h0;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 24;
  localparam int LANE_W      = 16;
  localparam int OPND_W      = 64;
  localparam int UPPER_LSB   = 16;
  localparam int ODD_QUAD_HALF = 3;
  localparam logic [2:0] HALF_OFFSET = 3'h4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [OPND_W-1:0] OPND_RESET = 64'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h0;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_DOUBLE,
    SIZE_QUAD
  } opnd_size_e;

  typedef enum logic [1:0] {
    KIND_MEMORY,
    KIND_SPECIAL,
    KIND_SLAVE
  } cycle_kind_e;

  typedef struct packed {
    cycle_kind_e       kind;
    logic              write;
    opnd_size_e        size;
    logic [ADDR_W-1:0] addr;
    logic [OPND_W-1:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic [1:0] cat;
    logic [2:0] off;
  } piece_s;

endpackage : bus_seq_pkg

/* verilog/operand_splitter.sv */
`timescale 1ns/100ps

module operand_splitter (
  input  wire bus_seq_pkg::opnd_size_e size,
  input  wire logic                    odd,
  input  wire logic [2:0]              step,
  output bus_seq_pkg::piece_s          piece,
  output logic [2:0]                   count
);

  logic       half;
  logic [2:0] k;

  always_comb
  begin
    half  = (step >= 3'(bus_seq_pkg::ODD_QUAD_HALF));
    k     = half ? step - 3'(bus_seq_pkg::ODD_QUAD_HALF) : step;
    piece = '0;
    if (!odd)
    begin
      // even start: words at A, A+2, A+4, A+6
      piece.off = {step[1:0], 1'b0};
      piece.cat = (size == bus_seq_pkg::SIZE_BYTE)
                ? bus_seq_pkg::CAT_EVEN_BYTE
                : bus_seq_pkg::CAT_EVEN_WORD;
      unique case (size)
        bus_seq_pkg::SIZE_BYTE:   count = 3'h1;
        bus_seq_pkg::SIZE_WORD:   count = 3'h1;
        bus_seq_pkg::SIZE_DOUBLE: count = 3'h2;
        bus_seq_pkg::SIZE_QUAD:   count = 3'h4;
      endcase
    end
    else
    begin
      // odd start: odd byte, even word, even byte per half
      unique case (k)
        3'h0:
        begin
          piece.cat = bus_seq_pkg::CAT_ODD_BYTE;
          piece.off = 3'h0;
        end
        3'h1:
        begin
          piece.cat = (size == bus_seq_pkg::SIZE_WORD)
                    ? bus_seq_pkg::CAT_EVEN_BYTE
                    : bus_seq_pkg::CAT_EVEN_WORD;
          piece.off = 3'h1;
        end
        default:
        begin
          piece.cat = bus_seq_pkg::CAT_EVEN_BYTE;
          piece.off = 3'h3;
        end
      endcase
      if (half)
        piece.off = piece.off + bus_seq_pkg::HALF_OFFSET;
      unique case (size)
        bus_seq_pkg::SIZE_BYTE:   count = 3'h1;
        bus_seq_pkg::SIZE_WORD:   count = 3'h2;
        bus_seq_pkg::SIZE_DOUBLE: count = 3'h3;
        bus_seq_pkg::SIZE_QUAD:   count = 3'h6;
      endcase
    end
  end

endmodule : operand_splitter

/* tb/far_side_model.sv */
`timescale 1ns/100ps

module far_side_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] addr_data_low_out,
  input  wire logic        addr_data_low_oe,
  input  wire logic        address_strobe_n,
  input  wire logic        internal_access_strobe_n,
  input  wire logic        data_direction_in_n,
  input  wire logic        slave_cycle_strobe_n,
  input  wire logic [3:0]  cycle_status,
  input  wire logic [23:0] dsp_addr,
  input  wire logic        slv_arm,
  input  wire logic [15:0] slv_word,
  output logic      [15:0] addr_data_low_in,
  output logic      [15:0] dsp_rdata,
  output logic      [3:0]  cap_status,
  output logic      [15:0] cap_data
);
  logic [7:0]  word_r;
  logic [15:0] last_r;
  logic [15:0] bank_w;

  // ---------------------------------------------------------------
  // memory banks, module data and the shared wire
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
    if (!address_strobe_n || !internal_access_strobe_n)
      word_r <= addr_data_low_out[7:0];

  // low bank answers the even byte, high bank the odd byte of a word
  assign bank_w = {word_r[7:1], 1'b1, word_r[7:1], 1'b0} ^ 16'h5A5A;
  assign dsp_rdata = {dsp_addr[7:1], 1'b1, dsp_addr[7:1], 1'b0} ^ 16'hC3C3;

  // an undriven bus shows the inverse of its last level, so stale data
  // can never pass for a real answer
  assign addr_data_low_in = addr_data_low_oe ? addr_data_low_out :
                            slv_arm ? slv_word :
                            !data_direction_in_n ? bank_w : ~last_r;

  always_ff @(posedge core_clk)
    last_r <= addr_data_low_in;

  // ---------------------------------------------------------------
  // coprocessor latches
  // ---------------------------------------------------------------
  always_ff @(negedge slave_cycle_strobe_n)
    cap_status <= cycle_status;

  always_ff @(posedge slave_cycle_strobe_n)
    cap_data <= addr_data_low_in;
endmodule : far_side_model

/* tb/test_cpu_bus_cycle_sequencer.sv */
`timescale 1ns/100ps

module test_cpu_bus_cycle_sequencer;
  logic        core_clk, rst, req_valid, req_ready, resp_valid;
  logic        vector_busy, dsp_strobe, dsp_write, addr_data_low_oe;
  logic        high_byte_enable_n, addr_latch_enable, address_strobe_n;
  logic        timing_state_out_n, data_buffer_enable_n, read_strobe_n;
  logic        write_strobe_n, internal_access_strobe_n, slv_arm;
  logic        slave_cycle_strobe_n, data_direction_in_n, continuous_wait_n;
  logic [63:0] resp_data;
  logic [23:0] dsp_addr;
  logic [15:0] dsp_wdata, dsp_rdata, addr_data_low_in, addr_data_low_out;
  logic [15:0] slv_word, cap_data;
  logic [7:0]  upper_address;
  logic [3:0]  cycle_status, cap_status;
  logic        cur_wr = 1'b0;
  logic        t2_r = 1'b0;
  logic [3:0]  prev_st = 4'h0;
  int          spec_cnt = 0;
  int          fails, num_checks;
  bus_seq_pkg::bus_req_s req;
  logic [23:0] pa[$], ea[$];
  logic [1:0]  pc[$], ec[$];
  logic [15:0] pd[$], ed[$], em[$];

  cpu_bus_cycle_sequencer dut (
    .core_clk, .rst, .req_valid, .req, .req_ready, .resp_valid, .resp_data,
    .vector_busy, .dsp_strobe, .dsp_write, .dsp_addr, .dsp_wdata,
    .dsp_rdata, .addr_data_low_in, .addr_data_low_out, .addr_data_low_oe,
    .upper_address, .high_byte_enable_n, .addr_latch_enable,
    .address_strobe_n, .timing_state_out_n, .data_buffer_enable_n,
    .read_strobe_n, .write_strobe_n, .internal_access_strobe_n,
    .slave_cycle_strobe_n, .data_direction_in_n, .cycle_status,
    .continuous_wait_n
  );

  far_side_model far (
    .core_clk, .addr_data_low_out, .addr_data_low_oe, .address_strobe_n,
    .internal_access_strobe_n, .data_direction_in_n, .slave_cycle_strobe_n,
    .cycle_status, .dsp_addr, .slv_arm, .slv_word, .addr_data_low_in,
    .dsp_rdata, .cap_status, .cap_data
  );

  // ---------------------------------------------------------------
  // clock, checking and closing
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // bus monitor
  // ---------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!rst)
    begin
      if (t2_r)
        pd.push_back(addr_data_low_out);
      t2_r = !address_strobe_n || !internal_access_strobe_n;
      if (t2_r)
      begin
        pa.push_back({upper_address, addr_data_low_out});
        pc.push_back({high_byte_enable_n, addr_data_low_out[0]});
      end
      if (!internal_access_strobe_n)
      begin
        check(cycle_status, bus_seq_pkg::STATUS_SIGNAL_PROCESSING_MODULE);
        check({dsp_strobe, dsp_write}, {1'b1, cur_wr});
        spec_cnt = 4;
      end
      if (spec_cnt > 0)
      begin
        check({addr_latch_enable, address_strobe_n, timing_state_out_n,
               data_buffer_enable_n, read_strobe_n, write_strobe_n}, 6'h3F);
        spec_cnt--;
      end
      if (!slave_cycle_strobe_n)
      begin
        check(cycle_status, bus_seq_pkg::STATUS_SLAVE);
        check(prev_st, bus_seq_pkg::STATUS_SLAVE);
        check({address_strobe_n, read_strobe_n, write_strobe_n,
               data_direction_in_n}, {3'h7, cur_wr});
        pd.push_back(addr_data_low_out);
      end
      prev_st = cycle_status;
    end
  end

  // ---------------------------------------------------------------
  // request driving and expected pieces
  // ---------------------------------------------------------------
  task automatic send(input bus_seq_pkg::cycle_kind_e k, input logic w,
                      input int s, input logic [23:0] a, input logic [63:0] d);
    int n;
    pa.delete();
    pc.delete();
    pd.delete();
    cur_wr = w;
    req = '{k, w, bus_seq_pkg::opnd_size_e'(s), a, d};
    req_valid = 1'b1;
    n = 0;
    do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 50);
    #1 req_valid = 1'b0;
  endtask : send

  task automatic wait_resp(output logic [63:0] r, output int lat);
    lat = 0;
    do
    begin
      @(posedge core_clk);
      lat++;
    end
    while (resp_valid !== 1'b1 && lat < 300);
    r = resp_data;
    #1;
  endtask : wait_resp

  // walks each four-byte half: odd byte, even words, trailing even byte
  task automatic build(input int n, input logic [23:0] a,
                       input logic [63:0] d);
    int i, h, e;
    ea.delete();
    ec.delete();
    ed.delete();
    em.delete();
    for (h = 0; h < n; h += 4)
    begin
      i = h;
      e = (n < 4) ? n : h + 4;
      while (i < e)
      begin
        ea.push_back(a + 24'(i));
        if (a[0] ^ i[0])
        begin
          ec.push_back(bus_seq_pkg::CAT_ODD_BYTE);
          ed.push_back({d[8*i +: 8], 8'h00});
          em.push_back(16'hFF00);
          i++;
        end
        else if (e - i > 1)
        begin
          ec.push_back(bus_seq_pkg::CAT_EVEN_WORD);
          ed.push_back(d[8*i +: 16]);
          em.push_back(16'hFFFF);
          i += 2;
        end
        else
        begin
          ec.push_back(bus_seq_pkg::CAT_EVEN_BYTE);
          ed.push_back({8'h00, d[8*i +: 8]});
          em.push_back(16'h00FF);
          i++;
        end
      end
    end
  endtask : build

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_split(input bus_seq_pkg::cycle_kind_e k);
    logic [63:0] r, e, m, d;
    logic [23:0] a;
    int w, s, o, j, n, lat;
    d = 64'h8877665544332211;
    // waits held on throughout special cycles must change nothing
    continuous_wait_n = (k != bus_seq_pkg::KIND_SPECIAL);
    for (w = 0; w < 2; w++)
      for (s = 0; s < 4; s++)
        for (o = 0; o < 2; o++)
        begin
          n = 1 << s;
          a = 24'hF0A3C0 + 24'(o);
          build(n, a, d);
          send(k, w[0], s, a, d);
          wait_resp(r, lat);
          check(pa.size(), ea.size());
          for (j = 0; j < ea.size(); j++)
          begin
            check(pa[j], ea[j]);
            check(pc[j], ec[j]);
            if (w)
              check(pd[j] & em[j], ed[j] & em[j]);
          end
          check(lat, (k == bus_seq_pkg::KIND_SPECIAL ? 2 : 1) + 4 * ea.size());
          if (!w)
          begin
            e = 64'h0;
            for (j = 0; j < n; j++)
              e[8*j +: 8] = 8'(a + 24'(j)) ^
                            (k == bus_seq_pkg::KIND_SPECIAL ? 8'hC3 : 8'h5A);
            m = (n == 8) ? '1 : (64'h1 << (8 * n)) - 64'h1;
            check(r & m, e);
          end
        end
    continuous_wait_n = 1'b1;
  endtask : t_split

  task automatic t_slave();
    logic [63:0] r, d, m;
    int w, s, j, n, lat;
    continuous_wait_n = 1'b0;
    for (w = 0; w < 2; w++)
      for (s = 0; s < 4; s++)
      begin
        n = (s < 2) ? 1 : 1 << (s - 1);
        d = w ? 64'hF1E2D3C4B5A69788 : {4{slv_word}};
        m = (s == 3) ? '1 : (64'h1 << (s == 0 ? 8 : 16 * n)) - 64'h1;
        slv_arm = !w;
        send(bus_seq_pkg::KIND_SLAVE, w[0], s, 24'h000000, d);
        wait_resp(r, lat);
        slv_arm = 1'b0;
        check(lat, 2 + 2 * n);
        check(pd.size(), n);
        check(pa.size(), 0);
        for (j = 0; j < n && w; j++)
          check(pd[j] & m[15:0], d[16*j +: 16] & m[15:0]);
        if (!w)
          check(r & m, d & m);
        check({cap_status, cap_data & m[15:0]},
              {bus_seq_pkg::STATUS_SLAVE, d[16*(n-1) +: 16] & m[15:0]});
      end
    continuous_wait_n = 1'b1;
  endtask : t_slave

  task automatic t_busy();
    logic [63:0] r;
    int lat;
    vector_busy = 1'b1;
    send(bus_seq_pkg::KIND_SPECIAL, 1'b1, 1, 24'h000100, 64'h0);
    repeat (6)
    begin
      @(posedge core_clk);
      check({internal_access_strobe_n, address_strobe_n}, 2'h3);
    end
    #1 vector_busy = 1'b0;
    @(posedge core_clk);
    check(internal_access_strobe_n, 1'b1);
    @(posedge core_clk);
    check(internal_access_strobe_n, 1'b0);
    wait_resp(r, lat);
    check(pa.size(), 1);
  endtask : t_busy

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    fails = 0;
    num_checks = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    vector_busy = 1'b0;
    continuous_wait_n = 1'b1;
    slv_arm = 1'b0;
    slv_word = 16'h6B9D;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    t_split(bus_seq_pkg::KIND_MEMORY);
    t_split(bus_seq_pkg::KIND_SPECIAL);
    t_slave();
    t_busy();
    end_sim();
  end

  initial
  begin
    #60000;
    fails++;
    end_sim();
  end
endmodule : test_cpu_bus_cycle_sequencer
